// ---- adc_pkg.sv ----
// Shared constants and types of the converter control block.
package adc_pkg;
   // Bus address width; registers sit at byte address four times their index.
   localparam int ADC_AW = 10;
   // Register indices.
   localparam logic [7:0] ADC_IDX_INTCTL = 8'h0B;
   localparam logic [7:0] ADC_IDX_FLAGS  = 8'h0C;
   localparam logic [7:0] ADC_IDX_RESH   = 8'h1E;
   localparam logic [7:0] ADC_IDX_CTRL   = 8'h1F;
   localparam logic [7:0] ADC_IDX_ENAB   = 8'h8C;
   localparam logic [7:0] ADC_IDX_RESL   = 8'h9E;
   localparam logic [7:0] ADC_IDX_ASEL   = 8'h9F;
   localparam logic [7:0] ADC_IDX_STAT   = 8'hA0;
   localparam logic [7:0] ADC_IDX_MASK   = 8'hA1;
   // Values after reset.
   localparam logic [7:0] ADC_RST_INTCTL = 8'h00;
   localparam logic [7:0] ADC_RST_FLAGS  = 8'h00;
   localparam logic [7:0] ADC_RST_CTRL   = 8'h00;
   localparam logic [7:0] ADC_RST_ENAB   = 8'h00;
   localparam logic [7:0] ADC_RST_ASEL   = 8'h0F;
   localparam logic [1:0] ADC_RST_STAT   = 2'h0;
   localparam logic [1:0] ADC_RST_MASK   = 2'h0;
   // Implemented bits of the flag, control and analog select registers.
   localparam logic [7:0] ADC_IMP_FLAGS  = 8'hC9;
   localparam logic [7:0] ADC_IMP_CTRL   = 8'hCF;
   localparam logic [7:0] ADC_IMP_ASEL   = 8'h7F;
   // Field positions.
   localparam int ADC_BIT_GLB  = 7;
   localparam int ADC_BIT_PERI = 6;
   localparam int ADC_BIT_IRQF = 6;
   localparam int ADC_BIT_GO   = 1;
   localparam int ADC_BIT_ON   = 0;
   localparam int ADC_ST_DONE  = 0;
   localparam int ADC_ST_ABORT = 1;
   // Conversion resolution.
   localparam int ADC_RES_BITS = 10;
   localparam int ADC_STEPS    = 1024;
   localparam logic [3:0] ADC_LAST_DEC = 4'hA;
   localparam logic [9:0] ADC_MSB_TRIAL = 10'h200;
   // Timing.
   localparam int ADC_CLK_NS   = 25;
   localparam int ADC_RC_NS    = 2000;
   localparam int ADC_RC_CYC   = (ADC_RC_NS + ADC_CLK_NS - 1) / ADC_CLK_NS;
   localparam logic [6:0] ADC_RC_LAST = 7'(ADC_RC_CYC - 1);
   localparam logic [3:0] ADC_INSTR_LAST = 4'h3;
   localparam logic [1:0] ADC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] ADC_RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic       justify;
      logic       vref;
      logic [1:0] unused;
      logic [1:0] chan;
      logic       go;
      logic       on;
   } adc_ctrl_t;
   typedef struct packed {
      logic       unused;
      logic [2:0] clksel;
      logic [3:0] pins;
   } adc_asel_t;
   typedef enum logic [1:0] {
      ADC_IDLE = 2'b00,
      ADC_WAIT = 2'b01,
      ADC_CONV = 2'b11
   } adc_state_t;
endpackage : adc_pkg

// ---- adc_ctrl.sv ----
// Converter control block: sequencing, result layout, sleep handling and registers.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Each sample resolves into 1024 steps, a 10-bit result.
// - Conversion survives sleep only with the RC conversion clock selected.
// - With RC clock, start is delayed by one instruction cycle after go.
// - At completion hardware clears go and loads both result registers.
// - Completion in sleep with converter interrupt enabled wakes the device.
// - Completion in sleep with interrupt disabled powers down; on bit stays.
// - Sleep without RC clock aborts conversion and powers down; on bit stays.
// - Reset restores control registers, switches off, aborts any conversion.
// - Reset leaves both result registers unchanged.
// - Unimplemented register bits read as zero.
// - Hold capacitor charge is never cleared between conversions.
// - Writing one to go with on also set starts a conversion; go reads one while running.
module adc_ctrl (
   input  wire logic                       aclk,          // System clock.
   input  wire logic                       aresetn,       // Synchronous reset, low.
   input  wire logic [adc_pkg::ADC_AW-1:0] s_axi_awaddr,  // Write address.
   input  wire logic                       s_axi_awvalid, // Write address valid.
   output logic                            s_axi_awready, // Write address ready.
   input  wire logic [31:0]                s_axi_wdata,   // Write data.
   input  wire logic [3:0]                 s_axi_wstrb,   // Write byte strobes.
   input  wire logic                       s_axi_wvalid,  // Write data valid.
   output logic                            s_axi_wready,  // Write data ready.
   output logic [1:0]                      s_axi_bresp,   // Write response.
   output logic                            s_axi_bvalid,  // Write response valid.
   input  wire logic                       s_axi_bready,  // Write response ready.
   input  wire logic [adc_pkg::ADC_AW-1:0] s_axi_araddr,  // Read address.
   input  wire logic                       s_axi_arvalid, // Read address valid.
   output logic                            s_axi_arready, // Read address ready.
   output logic [31:0]                     s_axi_rdata,   // Read data.
   output logic [1:0]                      s_axi_rresp,   // Read response.
   output logic                            s_axi_rvalid,  // Read data valid.
   input  wire logic                       s_axi_rready,  // Read data ready.
   input  wire logic                       sleep_i,       // Core is asleep.
   input  wire logic                       comp_i,        // Comparator, input above trial.
   output logic                            power_o,       // Analog section powered.
   output logic                            sample_o,      // Sampling switch closed.
   output logic [9:0]                      dac_o,         // Trial code to comparator.
   output logic [1:0]                      chan_o,        // Input channel select.
   output logic                            vref_o,        // Reference select.
   output logic [3:0]                      pins_o,        // Analog pin select.
   output logic                            irq_req_o,     // Core interrupt request.
   output logic                            wake_o,        // Wake pulse.
   output logic                            irq_o          // Status interrupt.
);
   import adc_pkg::*;

   adc_ctrl_t  ctrl_r;
   adc_asel_t  asel_r;
   adc_state_t st_r;
   adc_state_t st_nxt;
   logic [7:0] intctl_r;
   logic [7:0] flags_r;
   logic [7:0] enab_r;
   logic [7:0] resh_r;
   logic [7:0] resl_r;
   logic [1:0] stat_r;
   logic [1:0] mask_r;
   logic [9:0] sar_r;
   logic [3:0] bit_r;
   logic       pdn_r;
   logic [5:0] pre_r;
   logic [6:0] rc_r;
   logic       comp_m_r;
   logic       comp_s_r;
   logic       aw_ok_r;
   logic       w_ok_r;
   logic [7:0] widx_r;
   logic [7:0] wdat_r;
   logic       wstb_r;

   function automatic logic mapped(input logic [7:0] idx);
      mapped = idx inside {ADC_IDX_INTCTL, ADC_IDX_FLAGS, ADC_IDX_RESH,
                           ADC_IDX_CTRL, ADC_IDX_ENAB, ADC_IDX_RESL,
                           ADC_IDX_ASEL, ADC_IDX_STAT, ADC_IDX_MASK};
   endfunction : mapped

   // Bus handshakes and decode.
   wire       aw_hs     = s_axi_awvalid && s_axi_awready;
   wire       w_hs      = s_axi_wvalid && s_axi_wready;
   wire       ar_hs     = s_axi_arvalid && s_axi_arready;
   wire       wr_go     = aw_ok_r && w_ok_r && !s_axi_bvalid;
   wire       aw_ok_nxt = wr_go ? 1'b0 : (aw_ok_r || aw_hs);
   wire       w_ok_nxt  = wr_go ? 1'b0 : (w_ok_r || w_hs);
   wire       rv_nxt    = ar_hs || (s_axi_rvalid && !s_axi_rready);
   wire       wr_w      = wr_go && wstb_r;
   wire       wr_intctl = wr_w && widx_r == ADC_IDX_INTCTL;
   wire       wr_flags  = wr_w && widx_r == ADC_IDX_FLAGS;
   wire       wr_ctrl   = wr_w && widx_r == ADC_IDX_CTRL;
   wire       wr_enab   = wr_w && widx_r == ADC_IDX_ENAB;
   wire       wr_asel   = wr_w && widx_r == ADC_IDX_ASEL;
   wire       wr_mask   = wr_w && widx_r == ADC_IDX_MASK;
   wire [7:0] ridx      = s_axi_araddr[ADC_AW-1:2];
   wire       rd_clr    = ar_hs && ridx == ADC_IDX_STAT;
   // Unimplemented bits are masked at write time, so every read shows them as zero.
   wire [7:0] rmux =
      (ridx == ADC_IDX_INTCTL) ? intctl_r :
      (ridx == ADC_IDX_FLAGS)  ? flags_r :
      (ridx == ADC_IDX_RESH)   ? resh_r :
      (ridx == ADC_IDX_CTRL)   ? ctrl_r :
      (ridx == ADC_IDX_ENAB)   ? enab_r :
      (ridx == ADC_IDX_RESL)   ? resl_r :
      (ridx == ADC_IDX_ASEL)   ? asel_r :
      (ridx == ADC_IDX_STAT)   ? {6'h00, stat_r} :
      (ridx == ADC_IDX_MASK)   ? {6'h00, mask_r} : 8'h00;

   // Conversion clock: one divided tick per conversion step.
   wire [2:0] cs     = asel_r.clksel;
   wire       rc_sel = cs[1:0] == 2'b11;
   wire       div_tick =
      (cs == 3'b000) ? pre_r[0] :
      (cs == 3'b100) ? &pre_r[1:0] :
      (cs == 3'b001) ? &pre_r[2:0] :
      (cs == 3'b101) ? &pre_r[3:0] :
      (cs == 3'b010) ? &pre_r[4:0] : &pre_r[5:0];
   wire       tad_tick = rc_sel ? (rc_r == ADC_RC_LAST) : div_tick;

   // Successive approximation: one trial bit decided per tick, MSB first.
   wire       busy    = st_r != ADC_IDLE;
   wire       running = st_r == ADC_CONV && bit_r != 4'h0;
   wire [9:0] cur_w   = ADC_MSB_TRIAL >> (bit_r - 4'h1);
   wire [9:0] sar_dec = comp_s_r ? sar_r : (sar_r & ~cur_w);
   wire       done_ev = st_r == ADC_CONV && tad_tick && bit_r == ADC_LAST_DEC;
   wire       start_w = wr_ctrl && !busy && wdat_r[ADC_BIT_GO] && wdat_r[ADC_BIT_ON];
   wire       abt_wr  = wr_ctrl && busy && !(wdat_r[ADC_BIT_GO] && wdat_r[ADC_BIT_ON]);
   // Only the RC clock keeps running through sleep, so other sources must abort.
   wire       abt_slp = busy && sleep_i && !rc_sel;
   wire       abort   = abt_wr || abt_slp;
   wire       irq_en  = enab_r[ADC_BIT_IRQF];
   wire       slp_off = done_ev && sleep_i && !irq_en;
   wire [1:0] st_ev   = {abort, done_ev};

   always_comb
   begin
      st_nxt = st_r;
      unique case (st_r)
         ADC_IDLE:
         begin
            if (start_w)
               st_nxt = rc_sel ? ADC_WAIT : ADC_CONV;
         end
         ADC_WAIT:
         begin
            if (bit_r == ADC_INSTR_LAST)
               st_nxt = ADC_CONV;
         end
         ADC_CONV:
         begin
            if (done_ev)
               st_nxt = ADC_IDLE;
         end
         default:
         begin
            st_nxt = ADC_IDLE;
         end
      endcase
      if (abort)
         st_nxt = ADC_IDLE;
   end

   // Comparator comes from the analog side, hence two stages.
   always_ff @(posedge aclk)
   begin
      comp_m_r <= comp_i;
      comp_s_r <= comp_m_r;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pre_r <= 6'h00;
         rc_r  <= 7'h00;
      end
      else
      begin
         pre_r <= pre_r + 6'h01;
         rc_r  <= (rc_r == ADC_RC_LAST) ? 7'h00 : rc_r + 7'h01;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r  <= ADC_IDLE;
         bit_r <= 4'h0;
         sar_r <= 10'h000;
      end
      else
      begin
         st_r <= st_nxt;
         if (st_nxt != st_r)
            bit_r <= 4'h0;
         else if (st_r == ADC_WAIT || (st_r == ADC_CONV && tad_tick))
            bit_r <= bit_r + 4'h1;
         if (st_r != ADC_CONV)
            sar_r <= 10'h000;
         else if (tad_tick)
            sar_r <= (bit_r == 4'h0) ? ADC_MSB_TRIAL : (sar_dec | (cur_w >> 1));
      end
   end

   // Result registers carry no reset so that a reset keeps the last result.
   always_ff @(posedge aclk)
   begin
      if (aresetn && done_ev)
      begin
         resh_r <= ctrl_r.justify ? {6'h00, sar_dec[9:8]} : sar_dec[9:2];
         resl_r <= ctrl_r.justify ? sar_dec[7:0] : {sar_dec[1:0], 6'h00};
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r   <= ADC_RST_CTRL;
         asel_r   <= ADC_RST_ASEL;
         intctl_r <= ADC_RST_INTCTL;
         flags_r  <= ADC_RST_FLAGS;
         enab_r   <= ADC_RST_ENAB;
         mask_r   <= ADC_RST_MASK;
         stat_r   <= ADC_RST_STAT;
         pdn_r    <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_r <= wdat_r & ADC_IMP_CTRL;
         ctrl_r.go <= st_nxt != ADC_IDLE;
         if (wr_asel)
            asel_r <= wdat_r & ADC_IMP_ASEL;
         if (wr_intctl)
            intctl_r <= wdat_r;
         if (wr_enab)
            enab_r <= wdat_r & ADC_IMP_FLAGS;
         if (wr_mask)
            mask_r <= wdat_r[1:0];
         // A completion in the same cycle as a software clear keeps the flag set.
         flags_r <= (wr_flags ? (wdat_r & ADC_IMP_FLAGS) : flags_r)
                    | {1'b0, done_ev, 6'h00};
         stat_r <= (rd_clr ? 2'h0 : stat_r) | st_ev;
         if (abt_slp || slp_off)
            pdn_r <= 1'b1;
         else if (!sleep_i)
            pdn_r <= 1'b0;
      end
   end

   // Analog side and interrupt outputs.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         power_o   <= 1'b0;
         sample_o  <= 1'b0;
         dac_o     <= 10'h000;
         chan_o    <= 2'h0;
         vref_o    <= 1'b0;
         pins_o    <= 4'h0;
         irq_req_o <= 1'b0;
         wake_o    <= 1'b0;
         irq_o     <= 1'b0;
      end
      else
      begin
         power_o   <= ctrl_r.on && !pdn_r;
         // No discharge step: the hold node keeps its charge into the next sample.
         sample_o  <= ctrl_r.on && !pdn_r && !running;
         dac_o     <= sar_r;
         chan_o    <= ctrl_r.chan;
         vref_o    <= ctrl_r.vref;
         pins_o    <= asel_r.pins;
         irq_req_o <= flags_r[ADC_BIT_IRQF] && irq_en
                      && intctl_r[ADC_BIT_PERI] && intctl_r[ADC_BIT_GLB];
         wake_o    <= done_ev && sleep_i && irq_en;
         irq_o     <= |(stat_r & mask_r);
      end
   end

   // Register bus slave: one write and one read under way at a time.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ok_r       <= 1'b0;
         w_ok_r        <= 1'b0;
         widx_r        <= 8'h00;
         wdat_r        <= 8'h00;
         wstb_r        <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= ADC_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= ADC_RESP_OKAY;
      end
      else
      begin
         aw_ok_r       <= aw_ok_nxt;
         w_ok_r        <= w_ok_nxt;
         s_axi_awready <= !aw_ok_nxt;
         s_axi_wready  <= !w_ok_nxt;
         if (aw_hs)
            widx_r <= s_axi_awaddr[ADC_AW-1:2];
         if (w_hs)
         begin
            wdat_r <= s_axi_wdata[7:0];
            wstb_r <= s_axi_wstrb[0];
         end
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(widx_r) ? ADC_RESP_OKAY : ADC_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         s_axi_rvalid  <= rv_nxt;
         s_axi_arready <= !rv_nxt;
         if (ar_hs)
         begin
            s_axi_rdata <= {24'h00_0000, rmux};
            s_axi_rresp <= mapped(ridx) ? ADC_RESP_OKAY : ADC_RESP_SLVERR;
         end
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   go_clear_a: assert property (done_ev |=> !ctrl_r.go && flags_r[ADC_BIT_IRQF])
      else $error("Go or flag wrong after completion.");
   go_set_a: assert property (start_w |=> ctrl_r.go [*2])
      else $error("Go flag not set after start.");
   rc_delay_a: assert property ((start_w && rc_sel && !sleep_i)
      |=> (st_r == ADC_WAIT) [*4] ##1 st_r == ADC_CONV)
      else $error("RC start not delayed by one instruction.");
   slp_abort_a: assert property (abt_slp
      |=> st_r == ADC_IDLE && pdn_r && ctrl_r.on ##1 !power_o)
      else $error("Sleep did not abort and power down.");
   wake_up_a: assert property ((done_ev && sleep_i) |=> wake_o == $past(irq_en))
      else $error("Wake pulse wrong at sleep completion.");
   slp_off_a: assert property (slp_off |=> pdn_r && ctrl_r.on ##1 !power_o)
      else $error("Converter not powered down after sleep completion.");
   irq_req_a: assert property ((done_ev && irq_en && &intctl_r[7:6] && !wr_w)
      |=> ##1 irq_req_o)
      else $error("Interrupt request not raised.");
   just_right_a: assert property ((done_ev && ctrl_r.justify)
      |=> resh_r == {6'h00, $past(sar_dec[9:8])} && resl_r == $past(sar_dec[7:0]))
      else $error("Right-justified result misplaced.");
   just_left_a: assert property ((done_ev && !ctrl_r.justify)
      |=> resh_r == $past(sar_dec[9:2]) && resl_r[5:0] == 6'h00)
      else $error("Left-justified result misplaced.");
   rd_zero_a: assert property ((ar_hs && ridx == ADC_IDX_CTRL)
      |=> s_axi_rdata[31:8] == 24'h00_0000 && s_axi_rdata[5:4] == 2'h0)
      else $error("Unimplemented bits read nonzero.");
   rst_state_a: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> st_r == ADC_IDLE && ctrl_r == ADC_RST_CTRL && !power_o)
      else $error("Reset did not clear the converter.");

   conv_done_c: cover property (done_ev);
   slp_wake_c: cover property (done_ev && sleep_i && irq_en);
   slp_abort_c: cover property (abt_slp);
   stat_clr_c: cover property (rd_clr && stat_r != 2'h0);
endmodule : adc_ctrl
`default_nettype wire

// ---- adc_front_model.sv ----
// Behavioural model of the analog input pins and the sample-and-hold front end.
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
   input  wire logic            aclk,   // System clock.
   input  wire logic            power,  // Analog section powered.
   input  wire logic            sample, // Sampling switch closed.
   input  wire logic [1:0]      chan,   // Selected input pin.
   input  wire logic [9:0]      dac,    // Trial code from the converter.
   input  wire logic [3:0][9:0] vin,    // Level of each input pin, in steps.
   output var  logic            comp    // Comparator decision.
);
   logic [9:0] hold_r;
   initial hold_r = 10'h000;
   initial comp = 1'b0;
   // The hold charge only follows the pin while the switch is closed and is never cleared.
   always @(posedge aclk)
   begin
      if (power && sample)
         hold_r <= vin[chan];
   end
   // An unpowered comparator gives no decision, so it toggles rather than holding a level.
   always @(posedge aclk)
   begin
      if (power)
         comp <= (hold_r >= dac);
      else
         comp <= ~comp;
   end
endmodule : adc_front_model
`default_nettype wire

// ---- adc_ctrl_tb_top.sv ----
// Self-checking testbench of the converter control block with its analog front end.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_tb_top;
   import adc_pkg::*;
   localparam int LIM = 200;
   localparam int ACQ = 800; // Acquisition time of 20 us in clock cycles.
   logic aclk = 1'b0, aresetn = 1'b0, sleep_i = 1'b0;
   logic [ADC_AW-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'hF, pins;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, comp, power, sample, vref, irq_req, wake, irq;
   logic [1:0] bresp, rresp, chan, bresp_seen, rresp_seen;
   logic [9:0] dac;
   logic [3:0][9:0] vin = {10'h3FF, 10'h155, 10'h2B5, 10'h000};
   int tests_run = 0, n_fail = 0, n_wake = 0;

   adc_ctrl adc_ctrl_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sleep_i(sleep_i), .comp_i(comp), .power_o(power), .sample_o(sample), .dac_o(dac),
      .chan_o(chan), .vref_o(vref), .pins_o(pins), .irq_req_o(irq_req), .wake_o(wake),
      .irq_o(irq)
   );
   adc_front_model adc_front_model_i (
      .aclk(aclk), .power(power), .sample(sample), .chan(chan), .dac(dac), .vin(vin),
      .comp(comp)
   );

   always #12.5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      if (wake === 1'b1)
         n_wake <= n_wake + 1;
   end

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic guard(input bit ok);
      if (!ok)
      begin
         n_fail++;
         end_of_test;
      end
   endtask : guard

   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
   endtask : settle

   // Address and data are offered together; each is released at its own handshake.
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      int n;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < LIM; n++)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bresp_seen = bresp;
      guard(n < LIM);
   endtask : wr

   task automatic rd(input logic [7:0] idx, output logic [31:0] d);
      int n;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      for (n = 0; n < LIM; n++)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      rresp_seen = rresp;
      guard(n < LIM);
   endtask : rd

   task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] d;
      rd(idx, d);
      chk(d, {24'h000000, e});
      chk({30'h0, rresp_seen}, {30'h0, ADC_RESP_OKAY});
   endtask : rdchk

   task automatic conv_go(input logic [7:0] ctl);
      wr(ADC_IDX_CTRL, ctl);
      settle(ACQ);
      wr(ADC_IDX_CTRL, ctl | 8'h02);
   endtask : conv_go

   task automatic wait_idle;
      logic [31:0] d;
      int n;
      d = '1;
      for (n = 0; n < 1000 && d[ADC_BIT_GO] !== 1'b0; n++) rd(ADC_IDX_CTRL, d);
      guard(n < 1000);
   endtask : wait_idle

   initial
   begin
      logic [31:0] d;
      int n;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      settle(2);
      rdchk(ADC_IDX_INTCTL, 8'h00);
      rdchk(ADC_IDX_FLAGS, 8'h00);
      rdchk(ADC_IDX_CTRL, 8'h00);
      rdchk(ADC_IDX_ENAB, 8'h00);
      rdchk(ADC_IDX_ASEL, 8'h0F);
      rdchk(ADC_IDX_STAT, 8'h00);
      rdchk(ADC_IDX_MASK, 8'h00);
      rd(8'h40, d);
      chk(d, 32'h0);
      chk({30'h0, rresp_seen}, {30'h0, ADC_RESP_SLVERR});
      wr(8'h40, 8'hFF);
      chk({30'h0, bresp_seen}, {30'h0, ADC_RESP_SLVERR});
      wr(ADC_IDX_CTRL, 8'h30);
      rdchk(ADC_IDX_CTRL, 8'h00);
      wr(ADC_IDX_ASEL, 8'hFF);
      rdchk(ADC_IDX_ASEL, 8'h7F);
      wr(ADC_IDX_ENAB, 8'hFF);
      rdchk(ADC_IDX_ENAB, 8'hC9);
      wr(ADC_IDX_INTCTL, 8'hC0);
      wr(ADC_IDX_ENAB, 8'h40);
      wr(ADC_IDX_MASK, 8'h01);
      wr(ADC_IDX_ASEL, 8'h65);
      // Right-justified conversion of pin 1, then the interrupt paths.
      conv_go(8'hC5);
      rdchk(ADC_IDX_CTRL, 8'hC7);
      chk({31'h0, vref}, 32'h1);
      chk({30'h0, chan}, 32'h1);
      chk({28'h0, pins}, 32'h5);
      wait_idle;
      chk({31'h0, sample}, 32'h1);
      rdchk(ADC_IDX_RESH, 8'h02);
      rdchk(ADC_IDX_RESL, 8'hB5);
      rdchk(ADC_IDX_FLAGS, 8'h40);
      chk({31'h0, irq_req}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rdchk(ADC_IDX_STAT, 8'h01);
      settle(2);
      chk({31'h0, irq}, 32'h0);
      wr(ADC_IDX_INTCTL, 8'h40);
      settle(2);
      chk({31'h0, irq_req}, 32'h0);
      wr(ADC_IDX_FLAGS, 8'h00);
      // Left-justified conversion of pin 2.
      conv_go(8'h09);
      wait_idle;
      rdchk(ADC_IDX_RESH, 8'h55);
      rdchk(ADC_IDX_RESL, 8'h40);
      // Reset in mid-conversion.
      conv_go(8'h0D);
      settle(100);
      aresetn <= 1'b0;
      settle(4);
      aresetn <= 1'b1;
      settle(2);
      chk({31'h0, power}, 32'h0);
      rdchk(ADC_IDX_CTRL, 8'h00);
      rdchk(ADC_IDX_ASEL, 8'h0F);
      rdchk(ADC_IDX_RESH, 8'h55);
      rdchk(ADC_IDX_RESL, 8'h40);
      // Sleep with a divided clock aborts.
      wr(ADC_IDX_ASEL, 8'h6F);
      conv_go(8'h05);
      settle(20);
      sleep_i <= 1'b1;
      settle(5);
      chk({31'h0, power}, 32'h0);
      chk({31'h0, sample}, 32'h0);
      rdchk(ADC_IDX_CTRL, 8'h05);
      rdchk(ADC_IDX_STAT, 8'h02);
      sleep_i <= 1'b0;
      // Sleep with the RC clock and the interrupt enabled wakes the core.
      wr(ADC_IDX_ASEL, 8'h3F);
      wr(ADC_IDX_ENAB, 8'h40);
      conv_go(8'h05);
      sleep_i <= 1'b1;
      for (n = 0; n < 2000 && n_wake == 0; n++) @(posedge aclk);
      chk(n_wake, 1);
      sleep_i <= 1'b0;
      rdchk(ADC_IDX_CTRL, 8'h05);
      rdchk(ADC_IDX_RESH, 8'hAD);
      // Sleep with the RC clock and the interrupt disabled powers down.
      wr(ADC_IDX_ENAB, 8'h00);
      conv_go(8'h0D);
      sleep_i <= 1'b1;
      for (n = 0; n < 2000 && power !== 1'b0; n++) @(posedge aclk);
      chk({31'h0, power}, 32'h0);
      chk(n_wake, 1);
      rdchk(ADC_IDX_CTRL, 8'h0D);
      rdchk(ADC_IDX_RESH, 8'hFF);
      sleep_i <= 1'b0;
      end_of_test;
   end
endmodule : adc_ctrl_tb_top
`default_nettype wire
